/* host_model.sv */
// host side of the register port
// assumes the bench calls one task at a time
`timescale 1ns/1ps
module host_model (
   // clock and read data
   input logic core_clk,
   input logic [7:0] reg_rd_data_q,
   // register port
   output logic reg_wr_en = 1'b0,
   output logic reg_rd_en = 1'b0,
   output logic [7:0] reg_addr = 8'h00,
   output logic [7:0] reg_wr_data = 8'h00
);
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wr_data <= a[0] ? {1'b0, d[6:0]} : d;
      @(posedge core_clk);
      reg_wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd_en <= 1'b0;
      // registered answer stands from the edge after the strobe until the next read
      @(posedge core_clk);
      d = reg_rd_data_q;
   endtask
endmodule

/* mode2_cfg_pkg.sv */
// constants for the mode-2 regulator configuration register pair
// assumes an 8-bit register port driven by the serial target engine
package mode2_cfg_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] PRIMARY_ADDR = 8'h2A;
   localparam logic [7:0] SECONDARY_ADDR = 8'h2B;
   localparam logic [7:0] PRIMARY_RESET = 8'h1C;
   localparam logic [7:0] SECONDARY_RESET = 8'h4C;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int SHIP_BIT = 7;
   localparam int PIN_SEL_BIT = 6;
   localparam int CORE_CODE_MSB = 5;
   localparam int KEY_ACTION_BIT = 6;
   localparam int SYS_OFFSET_BIT = 5;
   localparam int SYS_CODE_MSB = 4;

   // ---------------------------------------------------------------
   // modes and voltage mapping, in millivolts
   // ---------------------------------------------------------------
   localparam logic [1:0] MODE_SETTING_0 = 2'h0;
   localparam logic [1:0] MODE_SETTING_2 = 2'h2;
   localparam logic [11:0] STEP_MV = 12'h019;
   localparam logic [11:0] CORE_BASE_MV = 12'h1F4;
   localparam logic [11:0] CORE_TOP_MV = 12'h5DC;
   localparam logic [11:0] CORE_FIXED_MV = 12'h708;
   localparam logic [5:0] CORE_TOP_CODE = 6'h28;
   localparam logic [5:0] CORE_FIXED_CODE = 6'h3F;
   localparam logic [11:0] SYS_BASE_MV = 12'h5DC;
   localparam logic [4:0] SYS_TOP_CODE = 5'h18;
   localparam logic [11:0] SYS_OFFSET_MV = 12'h4B0;

endpackage

/* mode2_cfg_sva.sv */
// checker for the mode-2 configuration registers
// assumes binding onto the register block, single clock
`timescale 1ns/1ps
module mode2_cfg_sva (
   // clock and reset
   input logic core_clk,
   input logic rst_b,
   // register port
   input logic reg_wr_en,
   input logic reg_rd_en,
   input logic [7:0] reg_addr,
   input logic [7:0] reg_wr_data,
   input logic [7:0] reg_rd_data_q,
   // controls
   input logic mode2_active_q,
   input logic ship_mode_q,
   input logic return_to_mode0_q,
   input logic [11:0] core_buck_mv_q,
   input logic [11:0] system_buck_mv_q
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence s_core_ones;
      reg_wr_en && reg_addr == 8'h2A && reg_wr_data[5:0] == 6'h3F;
   endsequence
   sequence s_sys_top;
      reg_wr_en && reg_addr == 8'h2B && reg_wr_data[5:0] == 6'h1F;
   endsequence
   property p_rd_hold; !$past(reg_rd_en) |-> $stable(reg_rd_data_q); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_ship; ship_mode_q |-> mode2_active_q; endproperty
   a_ship: assert property (p_ship) else $error("ship outside mode 2");
   property p_key_mode; return_to_mode0_q |-> mode2_active_q; endproperty
   a_key_mode: assert property (p_key_mode) else $error("return outside mode 2");
   property p_key_once; return_to_mode0_q |=> !return_to_mode0_q; endproperty
   a_key_once: assert property (p_key_once) else $error("return pulse too long");
   property p_core_rng;
      (core_buck_mv_q >= 12'h1F4 && core_buck_mv_q <= 12'h5DC && core_buck_mv_q % 25 == 0)
         || core_buck_mv_q == 12'h708;
   endproperty
   a_core_rng: assert property (p_core_rng) else $error("core value off grid");
   property p_sys_rng;
      (system_buck_mv_q >= 12'h5DC && system_buck_mv_q <= 12'h834)
         || (system_buck_mv_q >= 12'hA8C && system_buck_mv_q <= 12'hCE4);
   endproperty
   a_sys_rng: assert property (p_sys_rng) else $error("system value out of range");
   property p_core_ones; s_core_ones |-> ##2 core_buck_mv_q == 12'h708; endproperty
   a_core_ones: assert property (p_core_ones) else $error("all-ones core not 1800");
   property p_sys_top; s_sys_top |-> ##2 system_buck_mv_q == 12'h834; endproperty
   a_sys_top: assert property (p_sys_top) else $error("system code not clamped");
endmodule

/* mode2_regulator_config_regs.sv */
// mode-2 regulator configuration registers and their decoded controls
// assumes a register port from the serial target engine on core_clk and
// the present mode setting supplied by the mode controller
`timescale 1ns/1ps

// Behaviour
// - two read/write registers at 2Ah, 2Bh
// - primary bit 7 requests ship mode
// - pin-select 0 uses internal mode bits only
// - pin-select 1 uses external mode pins only
// - primary bits 5:0 core code, default 1.200 V
// - core code 0.5-1.5 V, clamp, ones 1.8 V
// - key action 0: falling key returns mode 0
// - key action 1: falling key changes nothing
// - secondary bit 5 adds 1.2 V offset
// - secondary bits 4:0 system code, default 01100
// - system code 1.5-2.1 V, clamps above
module mode2_regulator_config_regs (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // register port
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wr_data,
   output logic [7:0] reg_rd_data_q,
   // mode context
   input wire logic [1:0] current_mode,
   input wire logic mode_select_bit_0,
   input wire logic mode_select_bit_1,
   // pins
   input wire logic mode_select_pin_0,
   input wire logic mode_select_pin_1,
   input wire logic power_key_n,
   // controls
   output logic mode2_active_q,
   output logic ship_mode_q,
   output logic [1:0] mode_request_q,
   output logic return_to_mode0_q,
   output logic [11:0] core_buck_mv_q,
   output logic [11:0] system_buck_mv_q
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] primary;
      logic [7:0] secondary;
      logic [7:0] rd_data;
      logic key_prev;
      logic active;
      logic ship;
      logic [1:0] request;
      logic to_mode0;
      logic [11:0] core_mv;
      logic [11:0] sys_mv;
   } regs_s;

   // one flop bank: registers, read byte, key history and every output
   regs_s state_q;
   regs_s state_d;
   logic [2:0] pins_sync;

   // decoded targets matching the register defaults; assumes both default
   // codes sit in the linear part of their scale with no range offset
   localparam logic [11:0] CORE_RESET_MV = 12'(mode2_cfg_pkg::CORE_BASE_MV
      + 12'(mode2_cfg_pkg::PRIMARY_RESET[mode2_cfg_pkg::CORE_CODE_MSB:0]) * mode2_cfg_pkg::STEP_MV);
   localparam logic [11:0] SYS_RESET_MV = 12'(mode2_cfg_pkg::SYS_BASE_MV
      + 12'(mode2_cfg_pkg::SECONDARY_RESET[mode2_cfg_pkg::SYS_CODE_MSB:0]) * mode2_cfg_pkg::STEP_MV);

   // ---------------------------------------------------------------
   // decoding
   // ---------------------------------------------------------------
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
      hit = (addr == offset);
   endfunction

   // unmapped addresses read as a fixed byte rather than a floating bus
   function automatic logic [7:0] read_byte(input logic [7:0] addr, input logic [7:0] primary,
      input logic [7:0] secondary);
      if (hit(addr, mode2_cfg_pkg::PRIMARY_ADDR)) begin
         read_byte = primary;
      end else if (hit(addr, mode2_cfg_pkg::SECONDARY_ADDR)) begin
         read_byte = secondary;
      end else begin
         read_byte = mode2_cfg_pkg::UNMAPPED_READ;
      end
   endfunction

   // all ones is a separate fixed level, not part of the linear scale
   function automatic logic [11:0] core_mv_of(input logic [5:0] code);
      if (code == mode2_cfg_pkg::CORE_FIXED_CODE) begin
         core_mv_of = mode2_cfg_pkg::CORE_FIXED_MV;
      end else if (code > mode2_cfg_pkg::CORE_TOP_CODE) begin
         core_mv_of = mode2_cfg_pkg::CORE_TOP_MV;
      end else begin
         core_mv_of = 12'(mode2_cfg_pkg::CORE_BASE_MV + 12'(code) * mode2_cfg_pkg::STEP_MV);
      end
   endfunction

   // clamp before the offset so both ranges top out at the same step
   function automatic logic [11:0] sys_mv_of(input logic [4:0] code, input logic offset);
      logic [4:0] lin_code;
      lin_code = code;
      if (code > mode2_cfg_pkg::SYS_TOP_CODE) begin
         lin_code = mode2_cfg_pkg::SYS_TOP_CODE;
      end
      sys_mv_of = 12'(mode2_cfg_pkg::SYS_BASE_MV + 12'(lin_code) * mode2_cfg_pkg::STEP_MV);
      if (offset) begin
         sys_mv_of = 12'(sys_mv_of + mode2_cfg_pkg::SYS_OFFSET_MV);
      end
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   pin_sync #(
      .WIDTH(3)
   ) u_pin_sync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .pin_in({power_key_n, mode_select_pin_1, mode_select_pin_0}),
      .pin_sync_q(pins_sync)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic in_m2;
      logic key_fall;
      logic [5:0] core_code;
      logic [4:0] sys_code;
      in_m2 = (current_mode == mode2_cfg_pkg::MODE_SETTING_2);
      key_fall = state_q.key_prev & ~pins_sync[2];
      core_code = state_q.primary[mode2_cfg_pkg::CORE_CODE_MSB:0];
      sys_code = state_q.secondary[mode2_cfg_pkg::SYS_CODE_MSB:0];
      state_d = state_q;

      // ------------------------------------------------------------
      // register writes and reads
      // ------------------------------------------------------------
      // whole bytes stored, reserved bit included
      if (reg_wr_en && hit(reg_addr, mode2_cfg_pkg::PRIMARY_ADDR)) begin
         state_d.primary = reg_wr_data;
      end
      if (reg_wr_en && hit(reg_addr, mode2_cfg_pkg::SECONDARY_ADDR)) begin
         state_d.secondary = reg_wr_data;
      end
      // a read and a write on the same edge returns the old byte
      if (reg_rd_en) begin
         state_d.rd_data = read_byte(reg_addr, state_q.primary, state_q.secondary);
      end

      // ------------------------------------------------------------
      // mode, ship and key controls
      // ------------------------------------------------------------
      // third flop on the key level gives the edge, idle high after reset
      state_d.key_prev = pins_sync[2];
      state_d.active = in_m2;
      state_d.ship = in_m2 & state_q.primary[mode2_cfg_pkg::SHIP_BIT];

      // request follows the chosen source; held outside mode 2
      if (in_m2) begin
         if (state_q.primary[mode2_cfg_pkg::PIN_SEL_BIT]) begin
            state_d.request = pins_sync[1:0];
         end else begin
            state_d.request = {mode_select_bit_1, mode_select_bit_0};
         end
      end

      // key edge is one-cycle; debounce qualification is upstream
      state_d.to_mode0 = in_m2 & key_fall
         & ~state_q.secondary[mode2_cfg_pkg::KEY_ACTION_BIT]
         & (current_mode != mode2_cfg_pkg::MODE_SETTING_0);

      // ------------------------------------------------------------
      // voltage targets
      // ------------------------------------------------------------
      // computed in every mode so the regulator sees a settled value on entry
      state_d.core_mv = core_mv_of(core_code);
      state_d.sys_mv = sys_mv_of(sys_code, state_q.secondary[mode2_cfg_pkg::SYS_OFFSET_BIT]);
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q.primary <= mode2_cfg_pkg::PRIMARY_RESET;
         state_q.secondary <= mode2_cfg_pkg::SECONDARY_RESET;
         state_q.rd_data <= mode2_cfg_pkg::UNMAPPED_READ;
         state_q.key_prev <= 1'b1;
         state_q.active <= 1'b0;
         state_q.ship <= 1'b0;
         state_q.request <= mode2_cfg_pkg::MODE_SETTING_0;
         state_q.to_mode0 <= 1'b0;
         // targets mirror the register defaults
         state_q.core_mv <= CORE_RESET_MV;
         state_q.sys_mv <= SYS_RESET_MV;
      end else begin
         state_q <= state_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs, each straight from its flop
   // ---------------------------------------------------------------
   assign reg_rd_data_q = state_q.rd_data;
   assign mode2_active_q = state_q.active;
   assign ship_mode_q = state_q.ship;
   assign mode_request_q = state_q.request;
   assign return_to_mode0_q = state_q.to_mode0;
   assign core_buck_mv_q = state_q.core_mv;
   assign system_buck_mv_q = state_q.sys_mv;

endmodule

/* pin_sync.sv */
// two-flop synchroniser for a group of asynchronous pins
// assumes the pins are quasi-static relative to core_clk
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 3
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // pins and synchronised levels
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_sync_q
);

   // a zero-width bank cannot be built
   if (WIDTH < 1) begin : g_width_check
      $error("pin_sync: WIDTH must be at least 1");
   end

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } sync_s;

   sync_s state_q;
   sync_s state_d;

   always_comb begin
      state_d.meta = pin_in;
      state_d.sync = state_q.meta;
   end

   // reset to all ones: the key pin idles high, so no false edge at release
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= '1;
      end else begin
         state_q <= state_d;
      end
   end

   assign pin_sync_q = state_q.sync;

endmodule

/* tb.sv */
// self-checking bench for the mode-2 configuration registers
// assumes host_model drives the register port
`timescale 1ns/1ps
module tb;
   logic core_clk = 1'b0, rst_b = 1'b0, reg_wr_en, reg_rd_en, mode2_active_q, ship_mode_q, return_to_mode0_q;
   logic mode_select_bit_0 = 1'b0, mode_select_bit_1 = 1'b0, mode_select_pin_0 = 1'b0;
   logic mode_select_pin_1 = 1'b0, power_key_n = 1'b1;
   logic [1:0] current_mode = 2'h2, mode_request_q;
   logic [7:0] reg_addr, reg_wr_data, reg_rd_data_q, d;
   logic [11:0] core_buck_mv_q, system_buck_mv_q;
   int n_fail = 0, samples_checked = 0, p, m[2] = '{8'h1C, 8'h4C};
   int cc[6] = '{0, 28, 40, 41, 62, 63}, sc[5] = '{0, 12, 24, 25, 31};
   mode2_regulator_config_regs dut (.core_clk, .rst_b, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data,
      .reg_rd_data_q, .current_mode, .mode_select_bit_0, .mode_select_bit_1, .mode_select_pin_0,
      .mode_select_pin_1, .power_key_n, .mode2_active_q, .ship_mode_q, .mode_request_q, .return_to_mode0_q,
      .core_buck_mv_q, .system_buck_mv_q);
   host_model host (.core_clk, .reg_rd_data_q, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data);
   initial forever #5 core_clk = ~core_clk;
   initial begin
      #500us n_fail++;
      results();
   end
   task automatic chk(string n, logic [11:0] s, logic [11:0] e);
      samples_checked++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic results;
      $display("checks %0d errors %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // write, keep the model, read back; outputs have settled on return
   task automatic wrd(logic [7:0] a, logic [7:0] v);
      host.wr(a, v);
      m[a[0]] = a[0] ? {1'b0, v[6:0]} : v;
      host.rd(a, d);
      chk("reg", 12'(d), 12'(m[a[0]]));
   endtask
   function automatic int core_mv(int c);
      return c == 63 ? 1800 : 500 + 25 * (c > 40 ? 40 : c);
   endfunction
   initial begin
      p = $urandom(32'h532f);
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      host.rd(8'h2C, d);
      chk("unmapped", 12'(d), 12'h000);
      for (int i = 0; i < 2; i++) begin
         host.rd(8'(8'h2A + i), d);
         chk("reset", 12'(d), 12'(m[i]));
      end
      chk("core", core_buck_mv_q, 12'h4B0);
      chk("sys", system_buck_mv_q, 12'h708);
      for (int i = 0; i < 8; i++)
         wrd(8'(8'h2A + i % 2), 8'($urandom));
      foreach (cc[i]) begin
         wrd(8'h2A, 8'(cc[i]));
         chk("core", core_buck_mv_q, 12'(core_mv(cc[i])));
      end
      for (int o = 0; o < 2; o++) foreach (sc[i]) begin
         wrd(8'h2B, 8'(o * 32 + sc[i]));
         chk("sys", system_buck_mv_q, 12'(1500 + 25 * (sc[i] > 24 ? 24 : sc[i]) + 1200 * o));
      end
      wrd(8'h2A, 8'h9C);
      chk("ship", 12'(ship_mode_q), 12'h001);
      // leave mode 2: ship drops, request holds although the source moves
      current_mode <= 2'h0;
      mode_select_bit_1 <= 1'b1;
      repeat (3) @(negedge core_clk);
      chk("ship off", 12'(ship_mode_q), 12'h000);
      chk("active", 12'(mode2_active_q), 12'h000);
      chk("req held", 12'(mode_request_q), 12'h000);
      @(posedge core_clk);
      current_mode <= 2'h2;
      mode_select_bit_1 <= 1'b0;
      mode_select_bit_0 <= 1'b1;
      mode_select_pin_1 <= 1'b1;
      wrd(8'h2A, 8'h1C);
      chk("active", 12'(mode2_active_q), 12'h001);
      chk("ship clr", 12'(ship_mode_q), 12'h000);
      chk("req int", 12'(mode_request_q), 12'h001);
      wrd(8'h2A, 8'h5C);
      chk("req pin", 12'(mode_request_q), 12'h002);
      // key action 0 in mode 2, action 1, then outside mode 2
      for (int k = 0; k < 3; k++) begin
         wrd(8'h2B, k == 1 ? 8'h4C : 8'h0C);
         current_mode <= k == 2 ? 2'h0 : 2'h2;
         repeat (3) @(posedge core_clk);
         power_key_n <= 1'b0;
         p = 0;
         repeat (8) begin
            @(negedge core_clk);
            p += int'(return_to_mode0_q === 1'b1);
         end
         @(posedge core_clk);
         chk("key", 12'(p), 12'(k == 0));
         power_key_n <= 1'b1;
         current_mode <= 2'h2;
      end
      // mid-run reset: fields and controls fall back to their defaults at once
      wrd(8'h2A, 8'hA5);
      chk("ship", 12'(ship_mode_q), 12'h001);
      rst_b <= 1'b0;
      @(negedge core_clk);
      chk("ship rst", 12'(ship_mode_q), 12'h000);
      @(posedge core_clk);
      rst_b <= 1'b1;
      m = '{8'h1C, 8'h4C};
      for (int i = 0; i < 2; i++) begin
         host.rd(8'(8'h2A + i), d);
         chk("reset", 12'(d), 12'(m[i]));
      end
      chk("core", core_buck_mv_q, 12'h4B0);
      chk("sys", system_buck_mv_q, 12'h708);
      results();
   end
endmodule
bind mode2_regulator_config_regs mode2_cfg_sva sva (.core_clk, .rst_b, .reg_wr_en, .reg_rd_en, .reg_addr,
   .reg_wr_data, .reg_rd_data_q, .mode2_active_q, .ship_mode_q, .return_to_mode0_q, .core_buck_mv_q,
   .system_buck_mv_q);
